// ===== core/mie_motion_eval.sv
// Summary of operation
// (RULE1) low range: time one full signal period
// (RULE2) high range: count edges per measuring interval
// (RULE3) switch frequency follows configured measuring interval
// (RULE4) one-track sensor keeps 35 percent duty
// (RULE5) two-track sensor keeps 35 percent duty
// (RULE6) low range phases last at least 200us
// (RULE7) high range phases last at least 5us
// (RULE8) antivalent skew over 150us flags discrepancy
// (RULE9) inverted track may lead or lag
// (RULE10) direction only with two phase-shifted tracks
// (RULE11) sensor edges alternate between the two tracks
// (RULE12) primary leading means clockwise, lagging counterclockwise
// (RULE13) vibration filter tolerates single-track toggling
// (RULE14) selectable polarity: NO, NC, or both
// (RULE15) every level change counts as one impulse
// (RULE16) two edges on one track flag sequence error
`include "mie_defines.svh"

module mie_motion_eval #(
   parameter int DISC_CYCLES = `MIE_DISC_CYCLES,
   parameter int MS_CYCLES   = `MIE_MS_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdata,
   input  wire logic        trackA,
   input  wire logic        trackAInv,
   input  wire logic        trackB,
   input  wire logic        trackBInv,
   output logic             discFault,
   output logic             seqError,
   output logic             dirCw,
   output logic             dirValid,
   output logic             highRange
);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   // switch-over frequency table, Hz, indexed by interval in ms

   function automatic logic [11:0] limitHz(input logic twoTrk, input logic [10:0] ms);
      logic [11:0] f;
      f = 12'h000;
      if (twoTrk) begin
         if      (ms >= 11'h190) f = 12'h038;                // 400 ms -> 56 Hz
         else if (ms >= 11'h03c) f = 12'h090;
         else if (ms >= 11'h014) f = 12'h0fa;
         else if (ms >= 11'h00c) f = 12'h143;
         else if (ms >= 11'h008) f = 12'h18b;
         else                    f = 12'h22f;                // 4 ms -> 559 Hz
      end else begin
         if      (ms >= 11'h3e8) f = 12'h047;                // 1000 ms -> 71 Hz
         else if (ms >= 11'h0ac) f = 12'h0aa;
         else if (ms >= 11'h044) f = 12'h10f;
         else if (ms >= 11'h024) f = 12'h175;
         else if (ms >= 11'h018) f = 12'h1c8;
         else if (ms >= 11'h010) f = 12'h22f;
         else if (ms >= 11'h008) f = 12'h317;
         else                    f = 12'h45e;                // 4 ms -> 1118 Hz
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts once stages two and three agree

   logic [3:0] s1_q, s2_q, s3_q;
   logic [3:0] filt_q, filt_d;

   always_comb begin
      filt_d = filt_q;
      for (int i = 0; i < 4; i++) begin
         if (s2_q[i] == s3_q[i]) filt_d[i] = s3_q[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_q   <= 4'h0;
         s2_q   <= 4'h0;
         s3_q   <= 4'h0;
         filt_q <= 4'h0;
      end else begin
         s1_q   <= {trackBInv, trackB, trackAInv, trackA};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [4:0]  ctrl_q,  ctrl_d;
   logic [10:0] ival_q,  ival_d;
   logic [31:0] rdata_q, rdata_d;
   logic        discFault_q, discFault_d;
   logic        seqErr_q,    seqErr_d;
   logic        discSet, seqSet;
   logic        statusWr;
   logic [31:0] periodCycles;
   logic        periodValid;
   logic [31:0] edges_q;
   logic        dirCw_q, dirValid_q;
   mie_pkg::mie_range_t range_q;

   wire logic      twoTrack = ctrl_q[`MIE_CTRL_TWO_TRACK];
   wire logic      vibOn    = ctrl_q[`MIE_CTRL_VIB];
   mie_pkg::mie_pol_t pol;
   assign pol = mie_pkg::mie_pol_t'(ctrl_q[`MIE_CTRL_POL_HI:`MIE_CTRL_POL_LO]);

   assign statusWr = regWr && regAddr == `MIE_ADDR_STATUS;

   // writes and read mux; sticky bits are write-one-to-clear and a new event beats the clear
   always_comb begin
      ctrl_d      = ctrl_q;
      ival_d      = ival_q;
      rdata_d     = 32'h0;
      discFault_d = discFault_q;
      seqErr_d    = seqErr_q;
      if (regWr && regAddr == `MIE_ADDR_CTRL) ctrl_d = regWdata[4:0];
      if (regWr && regAddr == `MIE_ADDR_INTERVAL) begin
         // below the shortest interval the switch-over table has no row
         ival_d = (regWdata[10:0] < `MIE_INTERVAL_MIN) ? `MIE_INTERVAL_MIN : regWdata[10:0];
      end
      if (statusWr && regWdata[`MIE_ST_DISC]) discFault_d = 1'b0;
      if (statusWr && regWdata[`MIE_ST_SEQ])  seqErr_d    = 1'b0;
      if (discSet) discFault_d = 1'b1;                       // [RULE8]
      if (seqSet)  seqErr_d    = 1'b1;                       // [RULE16]
      if (regRd) begin
         unique case (regAddr)
            `MIE_ADDR_CTRL:     rdata_d = {27'h0, ctrl_q};
            `MIE_ADDR_INTERVAL: rdata_d = {21'h0, ival_q};
            `MIE_ADDR_STATUS:   rdata_d = {27'h0, highRange, dirValid_q, dirCw_q, seqErr_q, discFault_q};
            `MIE_ADDR_PERIOD:   rdata_d = periodCycles;
            `MIE_ADDR_EDGES:    rdata_d = edges_q;
            default:            rdata_d = 32'h0;             // unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_q      <= `MIE_CTRL_RESET;
         ival_q      <= `MIE_INTERVAL_RESET;
         rdata_q     <= 32'h0;
         discFault_q <= 1'b0;
         seqErr_q    <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         ival_q      <= ival_d;
         rdata_q     <= rdata_d;
         discFault_q <= discFault_d;
         seqErr_q    <= seqErr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // polarity and edges: NC inverts the primary level; the combined type pairs
   // an NO output with an NC output, so it is checked as an antivalent pair

   logic actA, actB, prevA_q, prevB_q;
   logic edgeA, edgeB, riseA;
   logic antivalChk;

   assign actA       = (pol == mie_pkg::MIE_POL_NC) ? ~filt_q[0] : filt_q[0];   // [RULE14]
   assign actB       = (pol == mie_pkg::MIE_POL_NC) ? ~filt_q[2] : filt_q[2];   // [RULE14]
   assign antivalChk = ctrl_q[`MIE_CTRL_ANTIVAL] || pol == mie_pkg::MIE_POL_NONC; // [RULE14]
   assign edgeA      = actA != prevA_q;                      // [RULE15]
   assign edgeB      = twoTrack && actB != prevB_q;          // [RULE15]
   assign riseA      = edgeA && actA;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prevA_q <= 1'b0;
         prevB_q <= 1'b0;
      end else begin
         prevA_q <= actA;
         prevB_q <= actB;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // discrepancy: a true line equal to its inverse means one edge is still pending;
   // either line may be the late one, only the duration counts

   logic        mismatch;
   logic [31:0] discCnt_q, discCnt_d;

   assign mismatch = antivalChk && ((filt_q[0] == filt_q[1]) || (twoTrack && filt_q[2] == filt_q[3])); // [RULE9]

   always_comb begin
      discCnt_d = 32'h0;
      discSet   = 1'b0;
      if (mismatch) begin
         discCnt_d = (discCnt_q >= 32'(DISC_CYCLES)) ? discCnt_q : discCnt_q + 32'h1;
         discSet   = discCnt_q >= 32'(DISC_CYCLES);         // [RULE8]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) discCnt_q <= 32'h0;
      else       discCnt_q <= discCnt_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // direction and sequence: A leading B is clockwise; an edge repeating on
   // the same track is a sequence error unless vibration at standstill is tolerated

   logic lastWasA_q, lastWasA_d, seenEdge_q, seenEdge_d;
   logic dirCw_d, dirValid_d;

   always_comb begin
      dirCw_d    = dirCw_q;
      dirValid_d = dirValid_q && twoTrack;                   // [RULE10]
      lastWasA_d = lastWasA_q;
      seenEdge_d = seenEdge_q && twoTrack;
      seqSet     = 1'b0;
      if (twoTrack && (edgeA || edgeB)) begin
         // simultaneous edges on both tracks carry no order; direction holds
         if (edgeA && !edgeB) begin
            dirCw_d    = actA != actB;                       // [RULE12]
            dirValid_d = 1'b1;                               // [RULE10]
            seqSet     = seenEdge_q && lastWasA_q && !vibOn; // [RULE16] [RULE13]
            lastWasA_d = 1'b1;
         end else if (edgeB && !edgeA) begin
            dirCw_d    = actA == actB;                       // [RULE12]
            dirValid_d = 1'b1;
            seqSet     = seenEdge_q && !lastWasA_q && !vibOn; // [RULE16] [RULE11]
            lastWasA_d = 1'b0;
         end
         seenEdge_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dirCw_q    <= 1'b0;
         dirValid_q <= 1'b0;
         lastWasA_q <= 1'b0;
         seenEdge_q <= 1'b0;
      end else begin
         dirCw_q    <= dirCw_d;
         dirValid_q <= dirValid_d;
         lastWasA_q <= lastWasA_d;
         seenEdge_q <= seenEdge_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge counting per measuring interval

   logic [16:0] msCnt_q,   msCnt_d;
   logic [10:0] ivCnt_q,   ivCnt_d;
   logic [31:0] edgeCnt_q, edgeCnt_d;
   logic [31:0] edges_d;
   logic        msTick, ivEnd;
   logic [1:0]  newEdges;

   assign msTick   = msCnt_q == 17'(MS_CYCLES - 1);
   assign ivEnd    = msTick && ivCnt_q >= ival_q - 11'h1;
   assign newEdges = {1'b0, edgeA} + {1'b0, edgeB};

   always_comb begin
      msCnt_d   = msTick ? 17'h0 : msCnt_q + 17'h1;
      ivCnt_d   = msTick ? ivCnt_q + 11'h1 : ivCnt_q;
      edgeCnt_d = (edgeCnt_q > `MIE_EDGES_MAX - 32'h2) ? edgeCnt_q : edgeCnt_q + {30'h0, newEdges}; // [RULE2]
      edges_d   = edges_q;
      if (ivEnd) begin
         edges_d   = edgeCnt_d;                              // [RULE2]
         edgeCnt_d = 32'h0;
         ivCnt_d   = 11'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         msCnt_q   <= 17'h0;
         ivCnt_q   <= 11'h0;
         edgeCnt_q <= 32'h0;
         edges_q   <= 32'h0;
      end else begin
         msCnt_q   <= msCnt_d;
         ivCnt_q   <= ivCnt_d;
         edgeCnt_q <= edgeCnt_d;
         edges_q   <= edges_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // period timing on active rising edges of the primary track

   mie_period_meter mie_period_meter_i (
      .ref_clk      (ref_clk),
      .reset        (reset),
      .periodEdge   (riseA),
      .periodCycles (periodCycles),
      .periodValid  (periodValid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // method choice: frequency above the interval's limit means period*limit < clock rate

   mie_pkg::mie_range_t range_d;
   logic [43:0] periodTimesLimit;

   assign periodTimesLimit = periodCycles * limitHz(twoTrack, ival_q);

   always_comb begin
      range_d = range_q;
      if (periodValid || periodCycles == `MIE_PERIOD_MAX) begin
         range_d = (periodTimesLimit < `MIE_CLK_HZ) ? mie_pkg::MIE_RANGE_HIGH : mie_pkg::MIE_RANGE_LOW; // [RULE3]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) range_q <= mie_pkg::MIE_RANGE_LOW;
      else       range_q <= range_d;
   end

   assign highRange = range_q == mie_pkg::MIE_RANGE_HIGH;
   assign regRdata  = rdata_q;
   assign discFault = discFault_q;
   assign seqError  = seqErr_q;
   assign dirCw     = dirCw_q;
   assign dirValid  = dirValid_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_disc_fault_late : assert property (                     // [RULE8]
      $rose(discFault_q) |-> $past(discCnt_q) == 32'(DISC_CYCLES) && $past(mismatch))
      else $error("discrepancy flagged before window elapsed");

   a_disc_window_set : assert property (                     // [RULE8]
      mismatch && discCnt_q == 32'(DISC_CYCLES) |=> discFault_q)
      else $error("discrepancy not flagged after window");

   a_disc_skew_ok : assert property (                        // [RULE9]
      !mismatch |=> discCnt_q == 32'h0)
      else $error("skew counter kept running after lines agreed");

   a_sticky_set_wins : assert property (                     // [RULE8]
      discSet && statusWr && regWdata[`MIE_ST_DISC] |=> discFault_q)
      else $error("clear beat a new discrepancy");

   a_seq_repeat_a : assert property (                        // [RULE16]
      twoTrack && !vibOn && seenEdge_q && lastWasA_q && edgeA && !edgeB |=> seqErr_q)
      else $error("repeated primary edge not flagged");

   a_vib_filter : assert property (                          // [RULE13]
      vibOn && !seqErr_q |=> !seqErr_q)
      else $error("sequence error raised with vibration filter on");

   a_dir_clockwise : assert property (                       // [RULE12]
      twoTrack && edgeB && !edgeA && actA == actB |=> dirCw_q && dirValid_q)
      else $error("primary lead not reported clockwise");

   a_dir_one_track : assert property (                       // [RULE10]
      !twoTrack |=> !dirValid_q)
      else $error("direction valid without two tracks");

   a_edge_latch : assert property (                          // [RULE2]
      ivEnd && edgeCnt_q < 32'h1000 |=> edges_q == $past(edgeCnt_q) + {30'h0, $past(newEdges)} && edgeCnt_q == 32'h0)
      else $error("interval edge count not latched");

   a_range_switch : assert property (                        // [RULE3]
      periodValid |=> highRange == ($past(periodTimesLimit) < `MIE_CLK_HZ))
      else $error("method choice does not follow interval limit");

endmodule

// ===== core/mie_defines.svh
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// clock rate and derived time bases
`define MIE_CLK_HZ          44'h000_05f5_e100
`define MIE_CLK_MHZ         100
`define MIE_MS_CYCLES       (`MIE_CLK_MHZ * 1000)
`define MIE_DISC_TIME_US    150
`define MIE_DISC_CYCLES     (`MIE_DISC_TIME_US * `MIE_CLK_MHZ)

// register byte addresses
`define MIE_ADDR_CTRL       8'h00
`define MIE_ADDR_INTERVAL   8'h04
`define MIE_ADDR_STATUS     8'h08
`define MIE_ADDR_PERIOD     8'h0c
`define MIE_ADDR_EDGES      8'h10

// control fields
`define MIE_CTRL_TWO_TRACK  0
`define MIE_CTRL_ANTIVAL    1
`define MIE_CTRL_VIB        2
`define MIE_CTRL_POL_LO     3
`define MIE_CTRL_POL_HI     4
`define MIE_CTRL_RESET      5'h00

// status fields
`define MIE_ST_DISC         0
`define MIE_ST_SEQ          1
`define MIE_ST_CW           2
`define MIE_ST_DIR_VALID    3
`define MIE_ST_HIGH_RANGE   4

// measuring interval in ms
`define MIE_INTERVAL_RESET  11'h004
`define MIE_INTERVAL_MIN    11'h004

// saturated period and counter limits
`define MIE_PERIOD_MAX      32'hffff_ffff
`define MIE_EDGES_MAX       32'hffff_ffff

`endif

// ===== core/mie_pkg.sv
package mie_pkg;

   // sensor polarity selection
   typedef enum logic [1:0] {
      MIE_POL_NO   = 2'h0,
      MIE_POL_NC   = 2'h1,
      MIE_POL_NONC = 2'h2,
      MIE_POL_RSVD = 2'h3
   } mie_pol_t;

   // measuring method currently in use
   typedef enum logic [1:0] {
      MIE_RANGE_LOW  = 2'b01,
      MIE_RANGE_HIGH = 2'b10
   } mie_range_t;

endpackage

// ===== core/mie_period_meter.sv
`include "mie_defines.svh"

module mie_period_meter (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        periodEdge,
   output logic [31:0]      periodCycles,
   output logic             periodValid
);

   logic [31:0] cnt_q,    cnt_d;
   logic [31:0] period_q, period_d;
   logic        valid_q,  valid_d;

   // a full period runs from one active edge to the next; counter saturates at standstill
   always_comb begin
      cnt_d    = (cnt_q == `MIE_PERIOD_MAX) ? cnt_q : cnt_q + 32'h1;
      period_d = period_q;
      valid_d  = 1'b0;
      if (periodEdge) begin                                  // [RULE1]
         period_d = cnt_d;
         valid_d  = 1'b1;
         cnt_d    = 32'h0;
      end else if (cnt_q == `MIE_PERIOD_MAX) begin
         period_d = `MIE_PERIOD_MAX;                         // standstill reads as slowest
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_q    <= 32'h0;
         period_q <= `MIE_PERIOD_MAX;
         valid_q  <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         period_q <= period_d;
         valid_q  <= valid_d;
      end
   end

   assign periodCycles = period_q;
   assign periodValid  = valid_q;

   a_period_latch : assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
      periodEdge && cnt_q < 32'h100 |=> periodCycles == $past(cnt_q) + 32'h1 && periodValid)
      else $error("period not latched on active edge");

endmodule

// ===== verification/mie_sensor_model.sv
module mie_sensor_model (
   ref_clk,
   trackA,
   trackAInv,
   trackB,
   trackBInv
);
   timeunit 1ns;
   timeprecision 1ns;
   input  wire logic ref_clk;
   output logic      trackA;
   output logic      trackAInv;
   output logic      trackB;
   output logic      trackBInv;

   ////////////////////////////////////////////////////////////////////////////
   // push-pull outputs start at rest as antivalent pairs: true lines low, inverse lines high
   initial begin
      {trackA, trackAInv, trackB, trackBInv} = 4'h5;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one edge on a track; skew above 0 lets the inverse line lag, below 0 lead
   // a late true or inverse line is the only misbehaviour and only when asked for
   task automatic step(input int trk, input int skew, input int hold);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         if ((i == 0) == (skew >= 0)) begin
            if (trk == 0) trackA <= ~trackA;
            else trackB <= ~trackB;
         end else begin
            if (trk == 0) trackAInv <= ~trackAInv;
            else trackBInv <= ~trackBInv;
         end
         if (i == 0) repeat ((skew < 0) ? -skew : skew) @(posedge ref_clk);
      end
      repeat (hold) @(posedge ref_clk); // each phase held well past the minimum
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // free running square wave on the primary pair, 50 percent duty
   task automatic run_a(input int n, input int h);
      repeat (n) begin
         @(posedge ref_clk);
         trackA <= ~trackA; // symmetric pulse and pause
         trackAInv <= ~trackAInv;
         repeat (h - 1) @(posedge ref_clk);
      end
   endtask
endmodule

// ===== verification/motion_input_evaluator_test.sv
`include "mie_defines.svh"

module motion_input_evaluator_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DISC = 20;
   localparam int MSC  = 10;
   logic        ref_clk;
   logic        reset;
   logic        regWr;
   logic        regRd;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic [31:0] regRdata;
   logic [31:0] rd;
   logic        trackA;
   logic        trackAInv;
   logic        trackB;
   logic        trackBInv;
   logic        discFault;
   logic        seqError;
   logic        dirCw;
   logic        dirValid;
   logic        highRange;
   int          fail_count;
   int          total_checks;
   int          seed;
   int          h;
   int          mA;
   int          mB;
   int          expCw;
   int          expSeq;
   int          seqOn;
   int          edgeLog[$];

   ////////////////////////////////////////////////////////////////////////////
   // clock and parts
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   mie_motion_eval #(.DISC_CYCLES(DISC), .MS_CYCLES(MSC)) mie_motion_eval_i (
      .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trackA(trackA),
      .trackAInv(trackAInv), .trackB(trackB), .trackBInv(trackBInv),
      .discFault(discFault), .seqError(seqError), .dirCw(dirCw),
      .dirValid(dirValid), .highRange(highRange)
   );

   mie_sensor_model mie_sensor_model_i (
      .ref_clk(ref_clk), .trackA(trackA), .trackAInv(trackAInv),
      .trackB(trackB), .trackBInv(trackBInv)
   );

   ////////////////////////////////////////////////////////////////////////////
   // comparisons and closing
   task automatic check_reg(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_flag(input string what, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // register bus master, strobes one cycle long
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      reg_rd(a, rd);
      check_reg(what, e, rd);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // bench model: levels, direction and repeated-track history
   task automatic move(input int trk, input int skew);
      mie_sensor_model_i.step(trk, skew, 10);
      if (trk == 0) mA = 1 - mA;
      else mB = 1 - mB;
      expCw = (trk == 0) ? (mA != mB) : (mA == mB);
      if (seqOn != 0 && edgeLog.size() > 0 && edgeLog[$] == trk) expSeq = 1;
      edgeLog.push_back(trk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // hang guard, generous against about a thousand cycles of tests
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      $display("CHECK FAILED watchdog expected done seen hang");
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {reset, regWr, regRd, regAddr, regWdata} = {3'h4, 8'h00, 32'h0};
      {fail_count, total_checks, mA, mB, expCw, expSeq, seqOn} = '0;
      seed = 32'hfc97;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      // reset values, unmapped place, interval floor, read data lasts one cycle
      check_reg("flags after reset", 5'h00, {discFault, seqError, dirCw, dirValid, highRange});
      rd_chk("ctrl reset", `MIE_ADDR_CTRL, 32'h0);
      rd_chk("interval reset", `MIE_ADDR_INTERVAL, 32'h4);
      rd_chk("status reset", `MIE_ADDR_STATUS, 32'h0);
      settle(1);
      check_reg("read idle", 32'h0, regRdata);
      reg_wr(8'h14, $random(seed));
      rd_chk("unmapped", 8'h14, 32'h0);
      for (int i = 0; i < 3; i++) begin
         rd = (i == 0) ? 32'h2 : $random(seed);
         reg_wr(`MIE_ADDR_INTERVAL, rd);
         rd_chk("interval", `MIE_ADDR_INTERVAL, (rd[10:0] < 11'h4) ? 32'h4 : {21'h0, rd[10:0]});
      end
      reg_wr(`MIE_ADDR_INTERVAL, 32'h4);
      $display("test registers done");
      // one track: period timing, edges per 40-cycle interval, range choice
      h = (($random(seed) & 1) == 1) ? 5 : 10;
      fork
         mie_sensor_model_i.run_a(40, h);
         begin
            repeat (h * 30) @(posedge ref_clk);
            rd_chk("period", `MIE_ADDR_PERIOD, 2 * h);
            rd_chk("edges", `MIE_ADDR_EDGES, 40 / h);
            check_flag("high range", (2 * h * 1118) < 100000000, highRange);
         end
      join
      $display("test measuring done");
      // two tracks: forward walk, reversal, clearing, vibration filter
      seqOn = 1;
      reg_wr(`MIE_ADDR_CTRL, 32'h1);
      move(0, 0);
      reg_wr(`MIE_ADDR_STATUS, 32'h3);
      expSeq = 0;
      for (int i = 0; i < 3; i++) move((i + 1) % 2, 0);
      settle(2);
      check_flag("cw", 1'(expCw), dirCw);
      check_flag("dir valid", 1'b1, dirValid);
      check_flag("seq clean", 1'(expSeq), seqError);
      for (int i = 0; i < 4; i++) move((i + 1) % 2, 0);
      settle(2);
      check_flag("ccw", 1'(expCw), dirCw);
      check_flag("seq repeat", 1'(expSeq), seqError);
      reg_wr(`MIE_ADDR_STATUS, 32'h2);
      settle(2);
      check_flag("seq cleared", 1'b0, seqError);
      seqOn = 0;
      reg_wr(`MIE_ADDR_CTRL, 32'h5);
      move(1, 0);
      move(1, 0);
      check_flag("vibration", 1'b0, seqError);
      reg_wr(`MIE_ADDR_CTRL, 32'h0);
      move(0, 0);
      check_flag("one track dir", 1'b0, dirValid);
      $display("test direction done");
      // antivalent pairs: skew inside window either way, then too late
      reg_wr(`MIE_ADDR_CTRL, 32'h3);
      for (int t = 0; t < 2; t++) begin
         reg_wr(`MIE_ADDR_STATUS, 32'h3);
         move(t, 10);
         move(t, -(1 + ($random(seed) & 15)));
         check_flag("disc in window", 1'b0, discFault);
         // a clear that lands while the late edge is still pending must lose to the set
         fork
            move(t, 2 * DISC);
            begin
               settle(30);
               reg_wr(`MIE_ADDR_STATUS, 32'h1);
            end
         join
         check_flag("disc late", 1'b1, discFault);
         reg_rd(`MIE_ADDR_STATUS, rd);
         check_flag("disc status", 1'b1, rd[`MIE_ST_DISC]);
         reg_wr(`MIE_ADDR_STATUS, 32'h1);
         settle(2);
         check_flag("disc cleared", 1'b0, discFault);
      end
      $display("test antivalent done");
      // polarity codes NO, NC and combined: only the combined type pairs the lines
      for (int p = 0; p < 3; p++) begin
         reg_wr(`MIE_ADDR_CTRL, {27'h0, 2'(p), 3'h0});
         reg_wr(`MIE_ADDR_STATUS, 32'h3);
         move(0, 2 * DISC);
         check_flag("polarity pairing", mie_pkg::mie_pol_t'(p) == mie_pkg::MIE_POL_NONC, discFault);
      end
      $display("test polarity done");
      finish_test();
   end
endmodule
